// ### testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic stop_mode = 1'b0;
  logic [31:0] rdata;
  logic wait_req, rxd, rx_irq, err_irq;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int gl[4] = '{5, 8, 24, 152};
  logic [31:0] q;
  logic [8:0] v, w;
  int i;

  initial begin
    forever #4 clk = ~clk;
  end

  uart_rx_recovery_wakeup dut (.i_clk_sys(clk), .i_arst_n(arst_n), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_rxd(rxd),
    .i_stop_mode(stop_mode), .o_rx_irq(rx_irq), .o_err_irq(err_irq));
  tx_model tx (.i_clk(clk), .o_line(rxd));

  //////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // avalon access, held until waitrequest seen low
  task automatic acc(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr <= is_wr;
    rd <= ~is_wr;
    wdata <= d;
    @(posedge clk);
    while (wait_req !== 1'b0) @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(name, exp, q);
  endtask

  task automatic frame(input logic [8:0] val, input int n, input logic stop, input int g);
    tx.send(val, n, stop, g);
    repeat (4) @(posedge clk);
  endtask

  function automatic logic [31:0] exp_data(input logic [8:0] val, input logic nine);
    return nine ? {23'h0, val} : {23'h0, val[7], val[7:0]};
  endfunction

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      $display("CHECK FAILED timeout expected done seen hang");
      tally_and_finish();
    end
  end

  //////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h033d));
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk("ctrl_rst", 8'h00, 32'h0);
    rd_chk("baud_rst", 8'h10, 32'h43);
    rd_chk("status_rst", 8'h08, 32'h0);
    rd_chk("unmapped", 8'h14, 32'h0);
    acc(1'b1, 8'h10, 32'h1);
    acc(1'b1, 8'h04, 32'h3f);
    acc(1'b1, 8'h00, 32'h09);
    for (i = 0; i < 6; i++) begin
      v = (i == 0) ? 9'h0ff : (i == 1) ? 9'h000 : 9'($urandom());
      frame(v, 8, 1'b1, -1);
      chk("rx_irq", 32'h1, {31'h0, rx_irq});
      rd_chk("status_full", 8'h08, 32'h01);
      rd_chk("data8", 8'h0c, exp_data(v, 1'b0));
      rd_chk("status_read", 8'h08, 32'h0);
    end
    acc(1'b1, 8'h00, 32'h0b);
    for (i = 0; i < 3; i++) begin
      v = 9'($urandom());
      frame(v, 9, 1'b1, -1);
      rd_chk("data9", 8'h0c, exp_data(v, 1'b1));
    end
    acc(1'b1, 8'h00, 32'h09);
    // break: all zero with low stop
    frame(9'h000, 8, 1'b0, -1);
    chk("err_irq_fe", 32'h1, {31'h0, err_irq});
    rd_chk("status_fe", 8'h08, 32'h11);
    rd_chk("data_fe", 8'h0c, 32'h0);
    acc(1'b1, 8'h08, 32'h3f);
    v = 9'($urandom());
    w = 9'($urandom());
    frame(v, 8, 1'b1, -1);
    frame(w, 8, 1'b1, -1);
    rd_chk("status_or", 8'h08, 32'h05);
    chk("err_irq_or", 32'h1, {31'h0, err_irq});
    rd_chk("data_or", 8'h0c, exp_data(v, 1'b0));
    acc(1'b1, 8'h08, 32'h3f);
    // single sample upsets in start, start middle, data and stop
    for (i = 0; i < 4; i++) begin
      frame(9'h000, 8, 1'b1, gl[i]);
      chk("err_irq_nf", 32'h1, {31'h0, err_irq});
      rd_chk("status_nf", 8'h08, 32'h09);
      acc(1'b0, 8'h0c, 32'h0);
      acc(1'b1, 8'h08, 32'h3f);
    end
    for (i = 0; i < 4; i++) begin
      acc(1'b1, 8'h00, 32'h19 | {26'h0, i[0], 5'h0});
      v = 9'($urandom());
      frame(v, 8, 1'b1, -1);
      rd_chk("status_pe", 8'h08, {26'h0, (^v[7:0]) ^ i[0], 5'h01});
      acc(1'b0, 8'h0c, 32'h0);
      acc(1'b1, 8'h08, 32'h3f);
    end
    acc(1'b1, 8'h00, 32'h01);
    frame(9'($urandom()), 8, 1'b1, -1);
    acc(1'b0, 8'h0c, 32'h0);
    repeat (200) @(posedge clk);
    rd_chk("status_idle", 8'h08, 32'h02);
    chk("rx_irq_idle", 32'h1, {31'h0, rx_irq});
    acc(1'b1, 8'h00, 32'h45);
    @(posedge clk);
    chk("rx_irq_muted", 32'h0, {31'h0, rx_irq});
    frame(9'h012, 8, 1'b1, -1);
    rd_chk("status_drop", 8'h08, 32'h02);
    frame(9'h092, 8, 1'b1, -1);
    rd_chk("ctrl_woken", 8'h00, 32'h05);
    rd_chk("status_am", 8'h08, 32'h03);
    rd_chk("data_am", 8'h0c, exp_data(9'h092, 1'b0));
    repeat (200) @(posedge clk);
    acc(1'b1, 8'h08, 32'h3f);
    acc(1'b1, 8'h00, 32'h41);
    repeat (3) @(posedge clk);
    rd_chk("ctrl_idle_wake", 8'h00, 32'h01);
    rd_chk("status_no_flag", 8'h08, 32'h0);
    acc(1'b1, 8'h00, 32'h09);
    stop_mode <= 1'b1;
    frame(9'($urandom()), 8, 1'b1, -1);
    stop_mode <= 1'b0;
    rd_chk("status_stop", 8'h08, 32'h0);
    rd_chk("ctrl_stop", 8'h00, 32'h09);
    // low pulse too short to pass the start check
    tx.pulse(4);
    repeat (20) @(posedge clk);
    rd_chk("status_false_start", 8'h08, 32'h0);
    // slow sender, one extra tick per bit, kept in step by resync
    tx.set_len(17);
    frame(9'h055, 8, 1'b1, -1);
    tx.set_len(16);
    rd_chk("status_slow", 8'h08, 32'h01);
    rd_chk("data_slow", 8'h0c, exp_data(9'h055, 1'b0));
    v = 9'($urandom());
    frame(v, 8, 1'b1, -1);
    rd_chk("data_resume", 8'h0c, exp_data(v, 1'b0));
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire

// ### tx_model.sv
`timescale 1ns/10ps
`default_nettype none
module tx_model #(
  parameter int BIT_CLKS = 16
) (
  input wire logic i_clk,
  output logic o_line
);
  int bit_len = BIT_CLKS;
  initial o_line = 1'b1;
  // stretch or restore the bit time
  task automatic set_len(input int len);
    bit_len = len;
  endtask
  // short low pulse, line high afterwards
  task automatic pulse(input int len);
    repeat (len) begin
      @(posedge i_clk);
      o_line <= 1'b0;
    end
    @(posedge i_clk);
    o_line <= 1'b1;
  endtask
  // one frame, lsb first, line back high afterwards
  task automatic send(input logic [8:0] v, input int n, input logic stop, input int glitch);
    logic [10:0] fr;
    int k;
    fr = 11'h7ff;
    fr[0] = 1'b0;
    for (k = 0; k < n; k++) fr[k + 1] = v[k];
    fr[n + 1] = stop;
    for (k = 0; k < (n + 2) * bit_len; k++) begin
      @(posedge i_clk);
      o_line <= fr[k / bit_len] ^ (k == glitch);
    end
    @(posedge i_clk);
    o_line <= 1'b1;
  endtask
endmodule // tx_model
`default_nettype wire

// ### uart_rx_recovery_wakeup.sv
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module uart_rx_recovery_wakeup (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_rxd,
  input wire logic i_stop_mode,
  output logic o_rx_irq,
  output logic o_err_irq
);

logic ack_ff;
logic [31:0] rdata_ff;
urx_pkg::ctrl_s ctrl_ff;
urx_pkg::ctrl_s nxt_ctrl;
urx_pkg::flags_s irq_en_ff;
urx_pkg::flags_s stat_ff;
logic [8:0] data_ff;
logic [15:0] div_ff;
logic [15:0] div_cnt_ff;
logic rxd_m_ff;
logic rxd_s_ff;
urx_pkg::rx_state_e st_ff;
urx_pkg::rx_state_e nxt_st;
logic [4:0] rt_ff;
logic [4:0] nxt_rt;
logic [3:0] bit_cnt_ff;
logic [3:0] nxt_bit_cnt;
logic [8:0] sh_ff;
logic [8:0] nxt_sh;
logic [2:0] smp_ff;
logic [2:0] hist_ff;
logic nz_ff;
logic nxt_nz;
logic last_ff;
logic nxt_last;
logic [7:0] idle_cnt_ff;
logic armed_ff;

////////////////////////////////////////////////////////////////////////
// bus slave decode
wire req = i_avs_read | i_avs_write;
wire wr_go = i_avs_write & ack_ff;
wire rd_go = i_avs_read & ack_ff;
wire wr_lo = wr_go & i_avs_byteenable[0];
wire wr_hi = wr_go & i_avs_byteenable[1];
wire sel_ctrl = i_avs_address == urx_pkg::ADDR_CTRL;
wire sel_irq = i_avs_address == urx_pkg::ADDR_IRQ_EN;
wire sel_stat = i_avs_address == urx_pkg::ADDR_STATUS;
wire sel_data = i_avs_address == urx_pkg::ADDR_DATA;
wire sel_baud = i_avs_address == urx_pkg::ADDR_BAUD;
wire busy = st_ff != urx_pkg::ST_HUNT;
wire [31:0] rd_mux = sel_ctrl ? {25'h0, ctrl_ff} :
                     sel_irq ? {26'h0, irq_en_ff} :
                     sel_stat ? {25'h0, busy, stat_ff} :
                     sel_data ? {23'h0, data_ff} :
                     sel_baud ? {16'h0, div_ff} : 32'h0;

assign o_avs_waitrequest = req & ~ack_ff;
assign o_avs_readdata = rdata_ff;

always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    ack_ff <= 1'b0;
    rdata_ff <= 32'h0;
  end else begin
    ack_ff <= req & ~ack_ff;
    if (req & ~ack_ff) begin
      rdata_ff <= rd_mux;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// sample tick and line synchroniser
wire tick = ~i_stop_mode & (div_cnt_ff >= div_ff); // R1 R24
wire smp = rxd_s_ff;

always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    rxd_m_ff <= 1'b1;
    rxd_s_ff <= 1'b1;
    div_cnt_ff <= urx_pkg::DIV_FIRST;
    hist_ff <= 3'h0;
  end else begin
    rxd_m_ff <= i_rxd;
    rxd_s_ff <= rxd_m_ff;
    if (tick) begin
      div_cnt_ff <= urx_pkg::DIV_FIRST;
      hist_ff <= {hist_ff[1:0], smp};
    end else if (!i_stop_mode) begin
      div_cnt_ff <= div_cnt_ff + 16'h0001;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// sample points and votes
wire [2:0] v = {smp_ff[1:0], smp};
wire maj = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
wire agree = (&v) | ~(|v);
wire in_hunt = st_ff == urx_pkg::ST_HUNT;
wire in_start = st_ff == urx_pkg::ST_START;
wire in_data = st_ff == urx_pkg::ST_DATA;
wire in_stop = st_ff == urx_pkg::ST_STOP;
wire stby = ctrl_ff.standby;
wire nine = ctrl_ff.nine_bit;
wire pt_start = in_start & (rt_ff == urx_pkg::RT_S1 | rt_ff == urx_pkg::RT_S2 | rt_ff == urx_pkg::RT_S3);
wire pt_bit = rt_ff == urx_pkg::RT_D1 | rt_ff == urx_pkg::RT_D2 | rt_ff == urx_pkg::RT_D3;
wire start_edge = tick & in_hunt & ctrl_ff.rx_en & (hist_ff == urx_pkg::HIST_IDLE) & ~smp; // R2
wire ev_start = tick & in_start & (rt_ff == urx_pkg::RT_S3);
wire ev_bit = tick & ~in_hunt & (rt_ff == urx_pkg::RT_D3);
wire late = (rt_ff > urx_pkg::RT_D3) | (rt_ff < urx_pkg::RT_D1);
wire resync = tick & in_data & last_ff & hist_ff[0] & ~smp & late; // R10
wire adv = (tick & (rt_ff == urx_pkg::RT_LAST)) | (resync & (rt_ff > urx_pkg::RT_D3));
wire [3:0] nbits = nine ? urx_pkg::BITS_9 : urx_pkg::BITS_8; // R4

////////////////////////////////////////////////////////////////////////
// character completion
wire done = ev_bit & in_stop; // R11
wire [8:0] dat9 = nine ? sh_ff : {sh_ff[8], sh_ff[8:1]}; // R4
wire par_x = nine ? ^sh_ff : ^sh_ff[8:1];
wire pe = ctrl_ff.par_en & (par_x != ctrl_ff.par_odd); // R22
wire fe = ~maj; // R7 R9
wire nf = nz_ff | ~agree; // R7
wire wake_char = stby & ctrl_ff.wake_addr & dat9[8]; // R13
wire accept = ~stby | wake_char;
wire load = done & accept & ~stat_ff.full; // R17
wire ovr = done & accept & stat_ff.full; // R19

////////////////////////////////////////////////////////////////////////
// idle line detection
wire [7:0] idle_thr = nine ? urx_pkg::IDLE_9 : urx_pkg::IDLE_8; // R18
wire idle_lvl = idle_cnt_ff == idle_thr;
wire count_ok = smp & ~in_start & (~ctrl_ff.idle_after_stop | in_hunt); // R15
wire idle_evt = tick & count_ok & (idle_cnt_ff == idle_thr - 8'h01);
wire idle_flag = idle_evt & armed_ff & ~stby; // R14 R18
wire wake_idle = stby & ~ctrl_ff.wake_addr & idle_lvl; // R14 R16
wire wake_now = (done & wake_char) | wake_idle; // R13

always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    idle_cnt_ff <= 8'h00;
    armed_ff <= 1'b0;
  end else begin
    if (tick) begin
      if (!count_ok) begin
        idle_cnt_ff <= 8'h00;
      end else if (!idle_lvl) begin
        idle_cnt_ff <= idle_cnt_ff + 8'h01;
      end
    end
    if (start_edge) begin
      armed_ff <= 1'b1;
    end else if (idle_evt) begin
      armed_ff <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// receive sequencer
always_comb begin
  nxt_st = st_ff;
  nxt_rt = rt_ff;
  nxt_bit_cnt = bit_cnt_ff;
  nxt_sh = sh_ff;
  nxt_nz = nz_ff;
  nxt_last = last_ff;
  if (tick) begin
    nxt_rt = rt_ff + urx_pkg::RT_FIRST; // R1
    unique case (st_ff)
      urx_pkg::ST_HUNT: begin
        nxt_rt = urx_pkg::RT_ZERO;
        if (start_edge) begin
          nxt_st = urx_pkg::ST_START;
          nxt_rt = urx_pkg::RT_FIRST; // R2
          nxt_nz = 1'b0;
          nxt_last = 1'b0;
        end
      end
      urx_pkg::ST_START: begin
        if (ev_start) begin
          nxt_nz = ~agree; // R3
          if (maj) begin
            nxt_st = urx_pkg::ST_HUNT; // R5
            nxt_rt = urx_pkg::RT_ZERO; // R5
          end
        end
        if (ev_bit && (|v)) begin
          nxt_nz = 1'b1; // R8
        end
        if (adv) begin
          nxt_st = urx_pkg::ST_DATA;
          nxt_rt = urx_pkg::RT_FIRST;
          nxt_bit_cnt = 4'h0;
        end
      end
      urx_pkg::ST_DATA: begin
        if (ev_bit) begin
          nxt_sh = {maj, sh_ff[8:1]}; // R6
          nxt_last = maj;
          if (!agree) begin
            nxt_nz = 1'b1; // R6
          end
        end
        if (resync) begin
          nxt_rt = urx_pkg::RT_FIRST; // R10
        end
        if (adv) begin
          nxt_rt = urx_pkg::RT_FIRST;
          nxt_bit_cnt = bit_cnt_ff + 4'h1;
          if (bit_cnt_ff == nbits - 4'h1) begin
            nxt_st = urx_pkg::ST_STOP; // R4 R11
          end
        end
      end
      urx_pkg::ST_STOP: begin
        if (done) begin
          nxt_st = urx_pkg::ST_HUNT;
          nxt_rt = urx_pkg::RT_ZERO;
        end
      end
    endcase
    if (!ctrl_ff.rx_en) begin
      nxt_st = urx_pkg::ST_HUNT;
    end
  end
end

always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    st_ff <= urx_pkg::ST_HUNT;
    rt_ff <= urx_pkg::RT_ZERO;
    bit_cnt_ff <= 4'h0;
    sh_ff <= 9'h000;
    smp_ff <= 3'h0;
    nz_ff <= 1'b0;
    last_ff <= 1'b0;
  end else begin
    st_ff <= nxt_st;
    rt_ff <= nxt_rt;
    bit_cnt_ff <= nxt_bit_cnt;
    sh_ff <= nxt_sh;
    nz_ff <= nxt_nz;
    last_ff <= nxt_last;
    if (tick & (pt_start | pt_bit)) begin
      smp_ff <= v; // R3 R6 R7
    end
  end
end

////////////////////////////////////////////////////////////////////////
// registers
wire [5:0] set_v = {load & pe, load & fe, load & nf, ovr, idle_flag, load}; // R9 R17 R19
wire [5:0] clr_w = (wr_lo & sel_stat) ? i_avs_writedata[5:0] : 6'h00;
wire [5:0] clr_v = clr_w | {5'h00, rd_go & sel_data};

always_comb begin
  nxt_ctrl = ctrl_ff;
  if (wake_now) begin
    nxt_ctrl.standby = 1'b0; // R13 R14 R16
  end
  if (wr_lo & sel_ctrl) begin
    nxt_ctrl = urx_pkg::ctrl_s'(i_avs_writedata[6:0]); // R12
  end
end

always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    ctrl_ff <= urx_pkg::CTRL_RST;
    irq_en_ff <= urx_pkg::FLAGS_RST;
    stat_ff <= urx_pkg::FLAGS_RST;
    data_ff <= 9'h000;
    div_ff <= urx_pkg::DIV_RST;
  end else begin
    ctrl_ff <= nxt_ctrl;
    stat_ff <= urx_pkg::flags_s'((stat_ff & ~clr_v) | set_v);
    if (wr_lo & sel_irq) begin
      irq_en_ff <= urx_pkg::flags_s'(i_avs_writedata[5:0]);
    end
    if (load) begin
      data_ff <= dat9; // R19
    end
    if (wr_lo & sel_baud) begin
      div_ff[7:0] <= i_avs_writedata[7:0];
    end
    if (wr_hi & sel_baud) begin
      div_ff[15:8] <= i_avs_writedata[15:8];
    end
  end
end

////////////////////////////////////////////////////////////////////////
// interrupt requests, live in wait mode
wire rx_src = (stat_ff.full & irq_en_ff.full) | (stat_ff.idle & irq_en_ff.idle); // R17 R18
wire err_src = |(stat_ff[5:2] & irq_en_ff[5:2]); // R19 R20 R21 R22 R25
assign o_rx_irq = ~stby & rx_src; // R12 R23
assign o_err_irq = ~stby & err_src; // R12 R23 R25

////////////////////////////////////////////////////////////////////////
// checks
default clocking cb @(posedge i_clk_sys);
endclocking
default disable iff (!i_arst_n);

sequence s_edge;
  tick && in_hunt && ctrl_ff.rx_en && hist_ff == urx_pkg::HIST_IDLE && !smp;
endsequence

sequence s_req;
  req && o_avs_waitrequest;
endsequence

start_count_a: assert property (s_edge |=> in_start && rt_ff == urx_pkg::RT_FIRST) // R2
  else $error("start edge did not begin the tick count");
start_reject_a: assert property (ev_start && maj |=> in_hunt && rt_ff == urx_pkg::RT_ZERO) // R5
  else $error("rejected start did not restart hunt");
bit_noise_a: assert property (ev_bit && in_data && !agree |=> nz_ff) // R6
  else $error("data sample mismatch left noise clear");
frame_set_a: assert property (load && !maj |=> stat_ff.framing && stat_ff.full) // R9
  else $error("framing error not set with receive full");
standby_mute_a: assert property (ctrl_ff.standby |-> !o_rx_irq && !o_err_irq) // R12
  else $error("interrupt raised in standby");
addr_wake_a: assert property (done && wake_char && !stat_ff.full && !(wr_lo && sel_ctrl)
  |=> !ctrl_ff.standby && stat_ff.full) // R13
  else $error("address mark did not wake receiver");
overrun_keep_a: assert property (ovr |=> stat_ff.overrun && $stable(data_ff)) // R19
  else $error("overrun lost the buffered character");
stop_freeze_a: assert property (i_stop_mode |=> $stable(st_ff) && $stable(rt_ff) && $stable(stat_ff)) // R24
  else $error("receiver moved during stop mode");
bus_answer_a: assert property (s_req |=> !o_avs_waitrequest)
  else $error("bus request held off too long");

endmodule // uart_rx_recovery_wakeup
`default_nettype wire

// ### urx_pkg.sv
`default_nettype none
package urx_pkg;
////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1 - sample tick runs at sixteen times baud; ticks counted per bit
// R2 - start hunt needs three high samples then a low; count from edge
// R3 - start checked at ticks 3, 5, 7; one high allowed, disagreement is noise
// R4 - eight or nine data bits; ninth bit kept in bit 8
// R5 - failed start check clears tick count and restarts hunt
// R6 - data bit is majority of ticks 8, 9, 10; disagreement sets noise
// R7 - stop bit voted at ticks 8, 9, 10; low gives framing error, mismatch noise
// R8 - high start samples at ticks 8 to 10 set noise, bit still start
// R9 - framing error on missing stop or break, set with receive full
// R10 - tick count resynchronised on valid falling edges inside a character
// R11 - stop sampled 154 or 170 ticks after start edge
// R12 - standby request mutes every receiver interrupt
// R13 - address mark clears standby and sets receive full
// R14 - idle wake clears standby without idle or receive full flags
// R15 - idle count starts after start bit or after stop bit
// R16 - standby requested on an already idle line wakes at once
// R17 - receive full on character load; interrupt when enabled
// R18 - idle flag after 10 or 11 high bits; interrupt when enabled
// R19 - overrun keeps old character, drops new, error interrupt when enabled
// R20 - noise flag raises error interrupt when its enable is set
// R21 - framing flag raises error interrupt when its enable is set
// R22 - parity error flagged on bad parity; error interrupt when enabled
// R23 - receiver keeps running in wait; its interrupts can end wait
// R24 - stop mode freezes unit, registers kept, resumes afterwards
// R25 - error flags merge onto one error request, apart from receive request
////////////////////////////////////////////////////////////////////////
localparam logic [7:0] ADDR_CTRL = 8'h00;
localparam logic [7:0] ADDR_IRQ_EN = 8'h04;
localparam logic [7:0] ADDR_STATUS = 8'h08;
localparam logic [7:0] ADDR_DATA = 8'h0c;
localparam logic [7:0] ADDR_BAUD = 8'h10;

typedef struct packed {
  logic standby;
  logic par_odd;
  logic par_en;
  logic idle_after_stop;
  logic wake_addr;
  logic nine_bit;
  logic rx_en;
} ctrl_s;

typedef struct packed {
  logic parity;
  logic framing;
  logic noise;
  logic overrun;
  logic idle;
  logic full;
} flags_s;

typedef enum logic [1:0] {
  ST_HUNT = 2'h0,
  ST_START = 2'h1,
  ST_DATA = 2'h3,
  ST_STOP = 2'h2
} rx_state_e;

localparam ctrl_s CTRL_RST = 7'h00;
localparam flags_s FLAGS_RST = 6'h00;
localparam logic [15:0] DIV_RST = 16'h0043;
localparam logic [15:0] DIV_FIRST = 16'h0001;
localparam logic [4:0] RT_ZERO = 5'h00;
localparam logic [4:0] RT_FIRST = 5'h01;
localparam logic [4:0] RT_S1 = 5'h03;
localparam logic [4:0] RT_S2 = 5'h05;
localparam logic [4:0] RT_S3 = 5'h07;
localparam logic [4:0] RT_D1 = 5'h08;
localparam logic [4:0] RT_D2 = 5'h09;
localparam logic [4:0] RT_D3 = 5'h0a;
localparam logic [4:0] RT_LAST = 5'h10;
localparam logic [3:0] BITS_8 = 4'h8;
localparam logic [3:0] BITS_9 = 4'h9;
// ten or eleven bit times of sixteen ticks
localparam logic [7:0] IDLE_8 = 8'ha0;
localparam logic [7:0] IDLE_9 = 8'hb0;
localparam logic [2:0] HIST_IDLE = 3'h7;
endpackage
`default_nettype wire
